// File: common/ssp_irq_consts.svh
// register offsets, field positions and reset values of the interrupt block
`ifndef SSP_IRQ_CONSTS_SVH
`define SSP_IRQ_CONSTS_SVH

`define ADDR_W 12
`define OFS_MASK 12'h014
`define OFS_RAW 12'h018
`define OFS_MASKED 12'h01C
`define OFS_CLEAR 12'h020
`define OFS_IDENT4 12'hFD0
`define OFS_IDENT5 12'hFD4
`define OFS_IDENT6 12'hFD8
`define OFS_IDENT7 12'hFDC
`define OFS_IDENT0 12'hFE0

`define BIT_TX_LEVEL 3
`define BIT_RX_LEVEL 2
`define BIT_RX_TIMEOUT 1
`define BIT_RX_OVERRUN 0
`define NUM_STICKY 2

`define RST_TX_LEVEL 1'h1
`define RST_RX_LEVEL 1'h0
`define RST_STICKY 1'h0
`define RST_MASK 4'h0

`endif

// File: common/ssp_irq_pkg.sv
// types shared by the serial port interrupt block
package ssp_irq_pkg;
    typedef logic [3:0] src_vec_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_MASK = 3'b001,
        SEL_RAW = 3'b010,
        SEL_MASKED = 3'b011,
        SEL_CLEAR = 3'b100,
        SEL_IDENT_HI = 3'b101,
        SEL_IDENT0 = 3'b110
    } reg_sel_t;
endpackage

// File: rtl/irq_status_core.sv
// raw, masked and sticky interrupt status of the serial port
`timescale 1ns/1ns
`default_nettype none
`include "ssp_irq_consts.svh"
module irq_status_core
    import ssp_irq_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic txLevelHalf,
    input wire logic rxLevelHalf,
    input wire logic rxTimeoutEvent,
    input wire logic rxOverrunEvent,
    input wire logic maskWrite,
    input wire src_vec_t maskData,
    input wire logic clearWrite,
    input wire logic [1:0] clearData,
    output src_vec_t rawStatus,
    output src_vec_t interruptMask,
    output src_vec_t maskedStatus,
    output logic irqOut
);
    src_vec_t next_raw;
    src_vec_t next_mask;
    logic [1:0] stickyEvent;

    assign stickyEvent = {rxTimeoutEvent, rxOverrunEvent};
    assign next_raw[`BIT_TX_LEVEL] = txLevelHalf;
    assign next_raw[`BIT_RX_LEVEL] = rxLevelHalf;
    assign next_mask = maskWrite ? maskData : interruptMask;
    assign maskedStatus = rawStatus & interruptMask;

    // set wins over a clear in the same cycle, so no event is lost
    for (genvar i = 0; i < `NUM_STICKY; i++) begin : g_sticky
        assign next_raw[i] = stickyEvent[i]
            | (rawStatus[i] & ~(clearWrite & clearData[i]));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rawStatus <= {`RST_TX_LEVEL, `RST_RX_LEVEL,
                `RST_STICKY, `RST_STICKY};
            interruptMask <= `RST_MASK;
            irqOut <= 1'b0;
        end else begin
            rawStatus <= next_raw;
            interruptMask <= next_mask;
            irqOut <= |(next_raw & next_mask);
        end
    end
endmodule // irq_status_core
`default_nettype wire

// File: rtl/axil_reg_port.sv
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/1ns
`default_nettype none
`include "ssp_irq_consts.svh"
module axil_reg_port
    import ssp_irq_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire word_t wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output word_t rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire word_t readWord,
    input wire logic readHit,
    input wire logic writeHit,
    output logic writeFire,
    output logic [`ADDR_W-1:0] writeAddr,
    output word_t writeData,
    output logic [3:0] writeStrb
);
    logic awHeld;
    logic wHeld;
    logic awTake;
    logic wTake;
    logic arTake;

    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign arready = !rvalid;
    assign awTake = awvalid && awready;
    assign wTake = wvalid && wready;
    assign arTake = arvalid && arready;
    // acts once both halves are held; address and data come in any order
    assign writeFire = awHeld && wHeld && !bvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            writeAddr <= '0;
            writeData <= '0;
            writeStrb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awHeld <= 1'b1;
                writeAddr <= awaddr;
            end else if (writeFire) begin
                awHeld <= 1'b0;
            end
            if (wTake) begin
                wHeld <= 1'b1;
                writeData <= wdata;
                writeStrb <= wstrb;
            end else if (writeFire) begin
                wHeld <= 1'b0;
            end
            if (writeFire) begin
                bvalid <= 1'b1;
                bresp <= writeHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arTake) begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // axil_reg_port
`default_nettype wire

// File: rtl/sync_serial_port_irq.sv
// interrupt status, mask, clear and identification registers on axi4-lite
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_irq_consts.svh"
module sync_serial_port_irq
    import ssp_irq_pkg::*;
#(
    // arbitrary identification values
    parameter word_t IDENT_UPPER = 32'h5EC0_17A3,
    parameter logic [7:0] IDENT_LOW = 8'h6B
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire word_t wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output word_t rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic txLevelHalf,
    input wire logic rxLevelHalf,
    input wire logic rxTimeoutEvent,
    input wire logic rxOverrunEvent,
    output logic irqOut
);

    // ****************************************************************
    // address decode
    // ****************************************************************

    function automatic reg_sel_t decodeOfs(input logic [`ADDR_W-1:0] a);
        case (a)
            `OFS_MASK: decodeOfs = SEL_MASK;
            `OFS_RAW: decodeOfs = SEL_RAW;
            `OFS_MASKED: decodeOfs = SEL_MASKED;
            `OFS_CLEAR: decodeOfs = SEL_CLEAR;
            `OFS_IDENT4: decodeOfs = SEL_IDENT_HI;
            `OFS_IDENT5: decodeOfs = SEL_IDENT_HI;
            `OFS_IDENT6: decodeOfs = SEL_IDENT_HI;
            `OFS_IDENT7: decodeOfs = SEL_IDENT_HI;
            `OFS_IDENT0: decodeOfs = SEL_IDENT0;
            default: decodeOfs = SEL_NONE;
        endcase
    endfunction

    reg_sel_t readSel;
    reg_sel_t writeSel;
    logic readHit;
    logic writeHit;
    logic writeFire;
    logic [`ADDR_W-1:0] writeAddr;
    word_t writeData;
    logic [3:0] writeStrb;
    word_t readWord;
    logic [7:0] identHigh;
    logic maskWrite;
    logic clearWrite;
    logic lowLane;
    src_vec_t rawStatus;
    src_vec_t interruptMask;
    src_vec_t maskedStatus;

    assign readSel = decodeOfs(araddr);
    assign writeSel = decodeOfs(writeAddr);
    assign readHit = readSel != SEL_NONE;
    assign writeHit = writeSel != SEL_NONE;

    // ****************************************************************
    // write side effects
    // ****************************************************************

    // all fields live in byte lane 0; other lanes change nothing
    assign lowLane = writeFire && writeStrb[0];
    assign maskWrite = lowLane && writeSel == SEL_MASK;
    // raw, masked and identification words take no action on a write
    assign clearWrite = lowLane && writeSel == SEL_CLEAR;

    // ****************************************************************
    // read selection
    // ****************************************************************

    // byte index of the upper identifier is address bits 3:2
    assign identHigh = IDENT_UPPER[{araddr[3:2], 3'b000} +: 8];

    // unused and reserved bits read as zero
    assign readWord =
        (readSel == SEL_MASK) ? {28'h0, interruptMask} :
        (readSel == SEL_RAW) ? {28'h0, rawStatus} :
        (readSel == SEL_MASKED) ? {28'h0, maskedStatus} :
        (readSel == SEL_IDENT_HI) ? {24'h0, identHigh} :
        (readSel == SEL_IDENT0) ? {24'h0, IDENT_LOW} :
        32'h0;

    // ****************************************************************
    // bus slave and status core
    // ****************************************************************

    axil_reg_port u_port (
        .clk(clk),
        .arst_n(arst_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .readWord(readWord),
        .readHit(readHit),
        .writeHit(writeHit),
        .writeFire(writeFire),
        .writeAddr(writeAddr),
        .writeData(writeData),
        .writeStrb(writeStrb)
    );

    // level sources are resampled every cycle, so they drop on their own
    irq_status_core u_core (
        .clk(clk),
        .arst_n(arst_n),
        .txLevelHalf(txLevelHalf),
        .rxLevelHalf(rxLevelHalf),
        .rxTimeoutEvent(rxTimeoutEvent),
        .rxOverrunEvent(rxOverrunEvent),
        .maskWrite(maskWrite),
        .maskData(writeData[3:0]),
        .clearWrite(clearWrite),
        .clearData(writeData[1:0]),
        .rawStatus(rawStatus),
        .interruptMask(interruptMask),
        .maskedStatus(maskedStatus),
        .irqOut(irqOut)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************

    logic arTake;
    assign arTake = arvalid && arready;

    a_raw_read_word: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel == SEL_RAW
        |=> rvalid && rdata == {28'h0, $past(rawStatus)}
    ) else $error("raw status read returned wrong word");

    a_tx_level_follow: assert property (
        @(posedge clk) disable iff (!arst_n)
        arst_n && $past(arst_n)
        |-> rawStatus[`BIT_TX_LEVEL] == $past(txLevelHalf)
    ) else $error("transmit level bit does not follow its source");

    a_rx_level_follow: assert property (
        @(posedge clk) disable iff (!arst_n)
        arst_n && $past(arst_n)
        |-> rawStatus[`BIT_RX_LEVEL] == $past(rxLevelHalf)
    ) else $error("receive level bit does not follow its source");

    a_timeout_set_wins: assert property (
        @(posedge clk) disable iff (!arst_n)
        rxTimeoutEvent |=> rawStatus[`BIT_RX_TIMEOUT]
    ) else $error("receive time-out event was lost");

    a_overrun_set_wins: assert property (
        @(posedge clk) disable iff (!arst_n)
        rxOverrunEvent |=> rawStatus[`BIT_RX_OVERRUN]
    ) else $error("receive overrun event was lost");

    a_masked_read_word: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel == SEL_MASKED
        |=> rdata == {28'h0, $past(rawStatus & interruptMask)}
    ) else $error("masked status read returned wrong word");

    a_mask_write_lands: assert property (
        @(posedge clk) disable iff (!arst_n)
        maskWrite |=> interruptMask == $past(writeData[3:0])
            && irqOut == |(rawStatus & $past(writeData[3:0]))
    ) else $error("mask write did not take effect");

    a_clear_timeout: assert property (
        @(posedge clk) disable iff (!arst_n)
        clearWrite && writeData[`BIT_RX_TIMEOUT] && !rxTimeoutEvent
        |=> !rawStatus[`BIT_RX_TIMEOUT]
    ) else $error("time-out clear did not clear");

    a_clear_zero_keeps: assert property (
        @(posedge clk) disable iff (!arst_n)
        clearWrite && !writeData[`BIT_RX_OVERRUN]
            && rawStatus[`BIT_RX_OVERRUN]
        |=> rawStatus[`BIT_RX_OVERRUN]
    ) else $error("writing zero cleared the overrun bit");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel != SEL_MASK |=> rdata[31:8] == 24'h0
    ) else $error("reserved bits read nonzero");

    a_ident_bytes: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel == SEL_IDENT_HI
        |=> rdata[7:0] == IDENT_UPPER[{$past(araddr[3:2]), 3'b000} +: 8]
    ) else $error("identifier byte out of order");

    a_ident_fixed: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel == SEL_IDENT0 |=> rdata == {24'h0, IDENT_LOW}
    ) else $error("identification byte changed");

    a_level_drops: assert property (
        @(posedge clk) disable iff (!arst_n)
        !txLevelHalf
        |=> !rawStatus[`BIT_TX_LEVEL]
    ) else $error("transmit level bit held after its condition ended");

    a_irq_any_masked: assert property (
        @(posedge clk) disable iff (!arst_n)
        irqOut == (|maskedStatus)
    ) else $error("interrupt output disagrees with masked status");

    a_write_answer: assert property (
        @(posedge clk) disable iff (!arst_n)
        writeFire |=> bvalid
            && bresp == ($past(writeHit) ? RESP_OKAY : RESP_SLVERR)
    ) else $error("write answer missing or wrong");

    a_read_holds: assert property (
        @(posedge clk) disable iff (!arst_n)
        rvalid && !rready |=> rvalid && $stable(rdata)
    ) else $error("read data dropped before it was taken");

    // ****************************************************************
    // further checks on registers and handshakes
    // ****************************************************************

    a_rx_level_drops: assert property (
        @(posedge clk) disable iff (!arst_n)
        !rxLevelHalf
        |=> !rawStatus[`BIT_RX_LEVEL]
    ) else $error("receive level bit held after its condition ended");

    a_clear_overrun: assert property (
        @(posedge clk) disable iff (!arst_n)
        clearWrite && writeData[`BIT_RX_OVERRUN] && !rxOverrunEvent
        |=> !rawStatus[`BIT_RX_OVERRUN]
    ) else $error("overrun clear did not clear");

    a_zero_keeps_timeout: assert property (
        @(posedge clk) disable iff (!arst_n)
        clearWrite && !writeData[`BIT_RX_TIMEOUT]
            && rawStatus[`BIT_RX_TIMEOUT]
        |=> rawStatus[`BIT_RX_TIMEOUT]
    ) else $error("writing zero cleared the time-out bit");

    // a write to the raw or masked status word may not drop a sticky bit or the mask
    a_ro_write_none: assert property (
        @(posedge clk) disable iff (!arst_n)
        writeFire && (writeSel == SEL_RAW || writeSel == SEL_MASKED)
        |=> $stable(interruptMask)
            && ($past(rawStatus[1:0]) & ~rawStatus[1:0]) == 2'b00
    ) else $error("write to a read-only status word had an effect");

    a_mask_read_word: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel == SEL_MASK
        |=> rdata == {28'h0, $past(interruptMask)}
    ) else $error("mask read returned wrong word");

    a_clear_reads_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && readSel == SEL_CLEAR |=> rdata == 32'h0
    ) else $error("clear register read nonzero");

    // unmapped or misaligned addresses answer with an error and no data
    a_unmapped_read: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake && !readHit |=> rresp == RESP_SLVERR && rdata == 32'h0
    ) else $error("unmapped read not refused");

    a_read_answer: assert property (
        @(posedge clk) disable iff (!arst_n)
        arTake |=> rvalid
            && rresp == ($past(readHit) ? RESP_OKAY : RESP_SLVERR)
    ) else $error("read answer missing or wrong");

    a_write_refused: assert property (
        @(posedge clk) disable iff (!arst_n)
        bvalid |-> !awready && !wready
    ) else $error("write channel ready while an answer is pending");

    a_read_refused: assert property (
        @(posedge clk) disable iff (!arst_n)
        rvalid |-> !arready
    ) else $error("read address ready while read data is pending");

    a_write_holds: assert property (
        @(posedge clk) disable iff (!arst_n)
        bvalid && !bready |=> bvalid && $stable(bresp)
    ) else $error("write answer dropped before it was taken");

endmodule // sync_serial_port_irq
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the serial port interrupt block
`timescale 1ns/1ns
`default_nettype none
`include "ssp_irq_consts.svh"
module tb_top
    import ssp_irq_pkg::*;
;
    // ************************************************
    // ** signals and design
    // ************************************************
    // arbitrary identification values
    localparam word_t ID_UP = 32'hA1B2C3D4;
    localparam logic [7:0] ID_LO = 8'h5A;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    word_t wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic txLevelHalf = 1'b1, rxLevelHalf = 1'b0;
    logic rxTimeoutEvent = 1'b0, rxOverrunEvent = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, irqOut;
    wire logic [1:0] bresp, rresp;
    wire word_t rdata;
    int errTotal = 0;
    int checks = 0;
    word_t rd;
    logic [1:0] rs;

    sync_serial_port_irq #(.IDENT_UPPER(ID_UP), .IDENT_LOW(ID_LO))
    u_sync_serial_port_irq (
        .clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .txLevelHalf(txLevelHalf), .rxLevelHalf(rxLevelHalf),
        .rxTimeoutEvent(rxTimeoutEvent), .rxOverrunEvent(rxOverrunEvent),
        .irqOut(irqOut)
    );

    always #50 clk = ~clk;

    // ************************************************
    // ** tasks
    // ************************************************
    task automatic chk(input string name, input word_t seen, input word_t exp);
        checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            errTotal++;
        end
    endtask

    // ready is looked at on the falling edge so the rising edge update
    // of the slave cannot race the sample; release follows the edge.
    // answer ready rises only once the answer is seen, so the slave
    // must hold its answer for a cycle
    task automatic wr(input logic [11:0] a, input word_t d,
                      output logic [1:0] r);
        logic aT, wT, s, b;
        aT = 1'b0;
        wT = 1'b0;
        s = 1'b0;
        b = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b0;
        while (!b) begin
            @(negedge clk);
            aT = awvalid && awready;
            wT = wvalid && wready;
            s = bvalid;
            b = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (aT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
            bready <= s && !b;
        end
    endtask

    task automatic rdw(input logic [11:0] a, output word_t d,
                       output logic [1:0] r);
        logic aT, s, v;
        v = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b0;
        while (!v) begin
            @(negedge clk);
            aT = arvalid && arready;
            s = rvalid;
            v = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (aT) arvalid <= 1'b0;
            rready <= s && !v;
        end
    endtask

    task automatic rchk(input string name, input logic [11:0] a,
                        input word_t exp);
        rdw(a, rd, rs);
        chk(name, rd, exp);
        chk("rresp", {30'h0, rs}, 32'h0);
    endtask

    task automatic pulse(input int which);
        @(posedge clk);
        if (which == 0) rxOverrunEvent <= 1'b1;
        else rxTimeoutEvent <= 1'b1;
        @(posedge clk);
        rxOverrunEvent <= 1'b0;
        rxTimeoutEvent <= 1'b0;
    endtask

    task automatic endSim();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************
    // ** table of plain reads after reset
    // ************************************************
    typedef struct {logic [11:0] a; word_t d; logic [1:0] r;} row_t;
    row_t rows [10] = '{
        '{`OFS_RAW, 32'h8, 2'b00},
        '{`OFS_MASKED, 32'h0, 2'b00},
        '{`OFS_MASK, 32'h0, 2'b00},
        '{`OFS_CLEAR, 32'h0, 2'b00},
        '{`OFS_IDENT4, {24'h0, ID_UP[7:0]}, 2'b00},
        '{`OFS_IDENT5, {24'h0, ID_UP[15:8]}, 2'b00},
        '{`OFS_IDENT6, {24'h0, ID_UP[23:16]}, 2'b00},
        '{`OFS_IDENT7, {24'h0, ID_UP[31:24]}, 2'b00},
        '{`OFS_IDENT0, {24'h0, ID_LO}, 2'b00},
        '{12'h019, 32'h0, 2'b10}
    };

    initial begin
        #(3000 * 100);
        errTotal++;
        endSim();
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            rdw(rows[i].a, rd, rs);
            chk("table data", rd, rows[i].d);
            chk("table resp", {30'h0, rs}, {30'h0, rows[i].r});
        end
        $display("test reset table done");

        // level sources follow their inputs with no clear
        txLevelHalf <= 1'b0;
        rxLevelHalf <= 1'b1;
        repeat (2) @(posedge clk);
        rchk("raw level", `OFS_RAW, 32'h4);
        txLevelHalf <= 1'b1;
        $display("test levels done");

        // masking and the combined output
        wr(`OFS_MASK, 32'hF, rs);
        rchk("masked all", `OFS_MASKED, 32'hC);
        @(negedge clk);
        chk("irq on", word_t'(irqOut), 32'h1);
        wr(`OFS_MASK, 32'h2, rs);
        rchk("masked none", `OFS_MASKED, 32'h0);
        @(negedge clk);
        chk("irq off", word_t'(irqOut), 32'h0);
        $display("test mask done");

        // sticky sources, clear by ones only, event beats clear
        pulse(1);
        rchk("raw timeout", `OFS_RAW, 32'hE);
        rchk("masked timeout", `OFS_MASKED, 32'h2);
        pulse(0);
        rchk("raw overrun", `OFS_RAW, 32'hF);
        wr(`OFS_CLEAR, 32'h0, rs);
        rchk("clear zero", `OFS_RAW, 32'hF);
        wr(`OFS_CLEAR, 32'h2, rs);
        rchk("clear timeout", `OFS_RAW, 32'hD);
        @(negedge clk);
        chk("irq cleared", word_t'(irqOut), 32'h0);
        wr(`OFS_CLEAR, 32'h1, rs);
        rchk("clear overrun", `OFS_RAW, 32'hC);
        @(posedge clk);
        rxTimeoutEvent <= 1'b1;
        wr(`OFS_CLEAR, 32'h2, rs);
        rchk("event held", `OFS_RAW, 32'hE);
        rxTimeoutEvent <= 1'b0;
        $display("test sticky done");

        // writes to read-only places change nothing
        wr(`OFS_RAW, 32'h0, rs);
        wr(`OFS_MASKED, 32'h0, rs);
        wr(`OFS_IDENT4, 32'hFF, rs);
        rchk("raw kept", `OFS_RAW, 32'hE);
        rchk("masked kept", `OFS_MASKED, 32'h2);
        rchk("ident kept", `OFS_IDENT4, {24'h0, ID_UP[7:0]});
        wr(12'h100, 32'hF, rs);
        chk("unmapped bresp", {30'h0, rs}, 32'h2);
        $display("test read only done");

        // reset in mid-run drops mask, sticky bits and output
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        chk("irq in reset", word_t'(irqOut), 32'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        rchk("raw after reset", `OFS_RAW, 32'hC);
        rchk("mask after reset", `OFS_MASK, 32'h0);
        $display("test second reset done");
        endSim();
    end
endmodule // tb_top
`default_nettype wire
